// ==== rtl/eifp_top.sv ====
// Purpose: External request controller with APB registers
// Assumes: pclk 100 MHz, presetn asynchronous active low, APB slave
//
// Chosen here: register access over APB.
`include "eifp_defines.svh"
`default_nettype none
module eifp_top #(
   parameter int N      = 6,
   parameter int ADDR_W = 12
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [N-1:0]      ext_req_input,
   input  wire logic [N-1:0]      exc_ack,
   output logic      [N-1:0]      core_req,
   output logic      [N-1:0]      req_prio,
   output logic                   watchdog_ref_prio,
   output logic      [4:0]        timer_prio,
   output logic                   dma_prio,
   output logic                   serial1_prio,
   output logic                   adc_prio,
   output logic                   irq
);
   // The decode and bit mapping are built for six inputs only
   if (N != 6)
   begin : g_bad_n
      $error("eifp_top supports N = 6 only");
   end
   if (ADDR_W < 10)
   begin : g_bad_addr
      $error("eifp_top needs ADDR_W of at least 10");
   end

   // Software visible registers and internal state flops
   logic [N-1:0]        sense_reg;     // Edge or level per input
   logic [N-1:0]        enable_reg;    // Per input enable
   logic [7:0]          prio_a_reg;    // First priority register
   logic [7:0]          prio_b_reg;    // Second priority register
   logic [N-1:0]        evt_stat_reg;  // Sticky flag-raise events
   logic [N-1:0]        evt_en_reg;    // Event interrupt enables
   logic [N-1:0]        armed_reg;     // Flags read as one
   logic [N-1:0]        flag_prev_reg; // Flags one cycle ago
   logic [N-1:0]        core_req_reg;  // Registered core requests
   logic                irq_reg;       // Registered interrupt level
   // APB answer flops
   logic [31:0]         prdata_reg;
   logic                pready_reg;
   logic                pslverr_reg;
   // Decode and strobes
   eifp_pkg::eifp_sel_t sel_c;         // Register hit by paddr
   logic                setup_c;       // APB setup cycle
   logic                access_c;      // Completing access edge
   logic                wr_c;          // Completing write, low lane
   logic                rd_c;          // Completing read
   logic [7:0]          wbyte_c;       // Write data, low byte
   logic [31:0]         rd_mux_c;      // Read data of addressed register
   logic [N-1:0]        evt_set_c;     // Flags rising this cycle
   logic [N-1:0]        flag_w;        // Flags from the bank

   eifp_det_if #(.N(N)) dif ();

   // Pin synchronisers and edge finders
   eifp_detect #(.N(N)) u_detect (
      .pclk    (pclk),
      .presetn (presetn),
      .pin_in  (ext_req_input),
      .dif     (dif)
   );

   // Status flags
   eifp_flag_bank #(.N(N)) u_bank (
      .pclk    (pclk),
      .presetn (presetn),
      .dif     (dif)
   );

   // Controls toward the bank
   assign dif.sense = sense_reg;
   assign dif.ack   = exc_ack;
   // Armed read-one then write-zero clear; ones are ignored
   assign dif.sw_clr = (wr_c && sel_c == eifp_pkg::EIFP_SEL_FLAGS)
                       ? (armed_reg & ~wbyte_c[N-1:0]) : '0;
   assign flag_w = dif.flag;

   // Address decode; byte address is four times the index
   always_comb
   begin
      sel_c = eifp_pkg::EIFP_SEL_NONE;
      if (paddr[1:0] == 2'h0 && paddr[ADDR_W-1:2] == (ADDR_W-2)'(`EIFP_IDX_SENSE))
         sel_c = eifp_pkg::EIFP_SEL_SENSE;
      else if (paddr[1:0] == 2'h0 && paddr[ADDR_W-1:2] == (ADDR_W-2)'(`EIFP_IDX_ENABLE))
         sel_c = eifp_pkg::EIFP_SEL_ENABLE;
      else if (paddr[1:0] == 2'h0 && paddr[ADDR_W-1:2] == (ADDR_W-2)'(`EIFP_IDX_FLAGS))
         sel_c = eifp_pkg::EIFP_SEL_FLAGS;
      else if (paddr[1:0] == 2'h0 && paddr[ADDR_W-1:2] == (ADDR_W-2)'(`EIFP_IDX_PRIO_A))
         sel_c = eifp_pkg::EIFP_SEL_PRIO_A;
      else if (paddr[1:0] == 2'h0 && paddr[ADDR_W-1:2] == (ADDR_W-2)'(`EIFP_IDX_PRIO_B))
         sel_c = eifp_pkg::EIFP_SEL_PRIO_B;
      else if (paddr[1:0] == 2'h0 && paddr[ADDR_W-1:2] == (ADDR_W-2)'(`EIFP_IDX_EVT_STAT))
         sel_c = eifp_pkg::EIFP_SEL_EVT_STAT;
      else if (paddr[1:0] == 2'h0 && paddr[ADDR_W-1:2] == (ADDR_W-2)'(`EIFP_IDX_EVT_CLR))
         sel_c = eifp_pkg::EIFP_SEL_EVT_CLR;
      else if (paddr[1:0] == 2'h0 && paddr[ADDR_W-1:2] == (ADDR_W-2)'(`EIFP_IDX_EVT_EN))
         sel_c = eifp_pkg::EIFP_SEL_EVT_EN;
   end

   // Transfer phases; the answer is ready in the first access cycle
   assign setup_c  = psel & ~penable;
   assign access_c = psel & penable & pready_reg;
   assign wr_c     = access_c & pwrite & pstrb[0] & ~pslverr_reg;
   assign rd_c     = access_c & ~pwrite & ~pslverr_reg;
   assign wbyte_c  = pwdata[7:0];

   // Read multiplexer; unused bits read zero, clear register reads zero
   always_comb
   begin
      rd_mux_c = 32'h0000_0000;
      unique case (sel_c)
         eifp_pkg::EIFP_SEL_SENSE:    rd_mux_c[N-1:0] = sense_reg;
         eifp_pkg::EIFP_SEL_ENABLE:   rd_mux_c[N-1:0] = enable_reg;
         eifp_pkg::EIFP_SEL_FLAGS:    rd_mux_c[N-1:0] = flag_w;
         eifp_pkg::EIFP_SEL_PRIO_A:   rd_mux_c[7:0]   = prio_a_reg;
         eifp_pkg::EIFP_SEL_PRIO_B:   rd_mux_c[7:0]   = prio_b_reg;
         eifp_pkg::EIFP_SEL_EVT_STAT: rd_mux_c[N-1:0] = evt_stat_reg;
         eifp_pkg::EIFP_SEL_EVT_EN:   rd_mux_c[N-1:0] = evt_en_reg;
         default:                     rd_mux_c        = 32'h0000_0000;
      endcase
   end

   // APB answer: data and error captured in setup, pready high one cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end
      else
      begin
         pready_reg <= setup_c;
         if (setup_c)
         begin
            // Unmapped addresses answer with an error, no effect
            pslverr_reg <= (sel_c == eifp_pkg::EIFP_SEL_NONE);
            prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux_c;
         end
         else
         begin
            pslverr_reg <= 1'b0;
         end
      end
   end

   // Sense select register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sense_reg <= `EIFP_RST_REQ;
      else if (wr_c && sel_c == eifp_pkg::EIFP_SEL_SENSE)
         sense_reg <= wbyte_c[N-1:0];
   end

   // Enable register, bits 5..0
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         enable_reg <= `EIFP_RST_REQ;
      else if (wr_c && sel_c == eifp_pkg::EIFP_SEL_ENABLE)
         enable_reg <= wbyte_c[N-1:0];
   end

   // Priority registers; reserved bits of the second stay zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prio_a_reg <= `EIFP_RST_BYTE;
         prio_b_reg <= `EIFP_RST_BYTE;
      end
      else if (wr_c && sel_c == eifp_pkg::EIFP_SEL_PRIO_A)
         prio_a_reg <= wbyte_c;
      else if (wr_c && sel_c == eifp_pkg::EIFP_SEL_PRIO_B)
         prio_b_reg <= wbyte_c & `EIFP_PRIO_B_MASK;
   end

   // Arming: a read records which flags were seen at one;
   // any write to the flags disarms, so one read permits one clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         armed_reg <= `EIFP_RST_REQ;
      else if (rd_c && sel_c == eifp_pkg::EIFP_SEL_FLAGS)
         armed_reg <= prdata_reg[N-1:0];
      else if (wr_c && sel_c == eifp_pkg::EIFP_SEL_FLAGS)
         armed_reg <= `EIFP_RST_REQ;
   end

   // Core requests gated by enables, registered for a clean output
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         core_req_reg <= `EIFP_RST_REQ;
      else
         core_req_reg <= flag_w & enable_reg;
   end

   // Event status: a flag rising is the event; set beats clear
   assign evt_set_c = flag_w & ~flag_prev_reg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag_prev_reg <= `EIFP_RST_REQ;
         evt_stat_reg  <= `EIFP_RST_REQ;
      end
      else
      begin
         flag_prev_reg <= flag_w;
         if (wr_c && sel_c == eifp_pkg::EIFP_SEL_EVT_CLR)
            evt_stat_reg <= (evt_stat_reg & ~wbyte_c[N-1:0]) | evt_set_c;
         else
            evt_stat_reg <= evt_stat_reg | evt_set_c;
      end
   end

   // Event enable register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         evt_en_reg <= `EIFP_RST_REQ;
      else if (wr_c && sel_c == eifp_pkg::EIFP_SEL_EVT_EN)
         evt_en_reg <= wbyte_c[N-1:0];
   end

   // Interrupt level; one cycle behind status, traded for a flop output
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_reg <= 1'b0;
      else
         irq_reg <= |(evt_stat_reg & evt_en_reg);
   end

   // Outputs
   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;
   assign core_req = core_req_reg;
   assign irq      = irq_reg;
   // First priority register fans out per source
   assign req_prio[0]   = prio_a_reg[`EIFP_PA_REQ0];
   assign req_prio[1]   = prio_a_reg[`EIFP_PA_REQ1];
   assign req_prio[2]   = prio_a_reg[`EIFP_PA_REQ23];
   assign req_prio[3]   = prio_a_reg[`EIFP_PA_REQ23];
   assign req_prio[4]   = prio_a_reg[`EIFP_PA_REQ45];
   assign req_prio[5]   = prio_a_reg[`EIFP_PA_REQ45];
   assign watchdog_ref_prio = prio_a_reg[`EIFP_PA_WDOG_REF];
   // Timer channels 0..2 sit in bits 2..0 in reverse order
   assign timer_prio[0] = prio_a_reg[`EIFP_PA_TMR0];
   assign timer_prio[1] = prio_a_reg[`EIFP_PA_TMR1];
   assign timer_prio[2] = prio_a_reg[`EIFP_PA_TMR2];
   // Second priority register
   assign timer_prio[3] = prio_b_reg[`EIFP_PB_TMR3];
   assign timer_prio[4] = prio_b_reg[`EIFP_PB_TMR4];
   assign dma_prio      = prio_b_reg[`EIFP_PB_DMA];
   assign serial1_prio  = prio_b_reg[`EIFP_PB_SER1];
   assign adc_prio      = prio_b_reg[`EIFP_PB_ADC];

   // Checks
   a_req_gate : assert property (@(posedge pclk) disable iff (!presetn)
      core_req == ($past(flag_w) & $past(enable_reg)))
      else $error("core request not flag and enable");
   a_enable_blocks : assert property (@(posedge pclk) disable iff (!presetn)
      !enable_reg[0] |=> !core_req[0]) else $error("disabled input requested");
   a_unarmed_keep : assert property (@(posedge pclk) disable iff (!presetn)
      wr_c && sel_c == eifp_pkg::EIFP_SEL_FLAGS && !armed_reg[0] && flag_w[0]
      && !exc_ack[0] |=> flag_w[0]) else $error("flag cleared without read");
   a_armed_clear : assert property (@(posedge pclk) disable iff (!presetn)
      wr_c && sel_c == eifp_pkg::EIFP_SEL_FLAGS && armed_reg[0] && !wbyte_c[0]
      && !dif.in_low[0] && !dif.fall[0] |=> !flag_w[0]) else $error("armed clear lost");
   a_one_keeps : assert property (@(posedge pclk) disable iff (!presetn)
      wr_c && sel_c == eifp_pkg::EIFP_SEL_FLAGS && wbyte_c[0] && flag_w[0]
      && !exc_ack[0] |=> flag_w[0]) else $error("write one changed flag");
   a_prio_map : assert property (@(posedge pclk) disable iff (!presetn)
      wr_c && sel_c == eifp_pkg::EIFP_SEL_PRIO_A |=> req_prio[0] == $past(pwdata[7])
      && timer_prio[0] == $past(pwdata[2])) else $error("priority mapping wrong");
   a_apb_ready : assert property (@(posedge pclk) disable iff (!presetn)
      setup_c |=> pready ##1 !pready) else $error("pready not one cycle");
   // Enable must still stand when status reaches the level flop
   a_irq_level : assert property (@(posedge pclk) disable iff (!presetn)
      evt_set_c[0] && evt_en_reg[0] ##1 evt_en_reg[0] |=> irq)
      else $error("irq not raised");

   // Register and interrupt checks
   // No enabled status, so the level drops a cycle later
   a_irq_quiet : assert property (@(posedge pclk) disable iff (!presetn)
      (evt_stat_reg & evt_en_reg) == '0 |=> !irq) else $error("irq without status");
   // Status bits are sticky until a clear write names them
   a_evt_sticky : assert property (@(posedge pclk) disable iff (!presetn)
      evt_stat_reg[0] && !(wr_c && sel_c == eifp_pkg::EIFP_SEL_EVT_CLR)
      |=> evt_stat_reg[0]) else $error("event status lost");
   // A one in the clear register drops the bit unless a new event lands
   a_evt_clear : assert property (@(posedge pclk) disable iff (!presetn)
      wr_c && sel_c == eifp_pkg::EIFP_SEL_EVT_CLR && wbyte_c[0] && !evt_set_c[0]
      |=> !evt_stat_reg[0]) else $error("event clear lost");
   // Level mode: a high input never raises its flag
   a_level_only : assert property (@(posedge pclk) disable iff (!presetn)
      !sense_reg[0] && !dif.in_low[0] && !flag_w[0] |=> !flag_w[0])
      else $error("level flag raised while high");
   // Edge mode: holding low after the edge raises nothing
   a_edge_only : assert property (@(posedge pclk) disable iff (!presetn)
      sense_reg[0] && !dif.fall[0] && !flag_w[0] |=> !flag_w[0])
      else $error("edge flag raised without edge");
   // Handling with input high clears a level flag
   a_level_clear : assert property (@(posedge pclk) disable iff (!presetn)
      !sense_reg[0] && exc_ack[0] && !dif.in_low[0] |=> !flag_w[0])
      else $error("level ack with input high kept flag");
   // Reserved bits of the second priority register stay zero
   a_prio_b_rsvd : assert property (@(posedge pclk) disable iff (!presetn)
      (prio_b_reg & ~`EIFP_PRIO_B_MASK) == 8'h00) else $error("reserved priority bit set");
   // An error answer only ever rides on pready
   a_error_ready : assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready) else $error("error without ready");
endmodule : eifp_top
`default_nettype wire

// ==== rtl/eifp_defines.svh ====
// Purpose: Offsets, field positions and reset values of the request controller
// Assumes: Register index times four gives the APB byte address
// Notes:   Definitions only
`ifndef EIFP_DEFINES_SVH
`define EIFP_DEFINES_SVH
`define EIFP_IDX_SENSE    8'hF4
`define EIFP_IDX_ENABLE   8'hF5
`define EIFP_IDX_FLAGS    8'hF6
`define EIFP_IDX_PRIO_A   8'hF8
`define EIFP_IDX_PRIO_B   8'hF9
`define EIFP_IDX_EVT_STAT 8'hFA
`define EIFP_IDX_EVT_CLR  8'hFB
`define EIFP_IDX_EVT_EN   8'hFC
`define EIFP_RST_BYTE     8'h00
`define EIFP_RST_REQ      6'h00
`define EIFP_PRIO_B_MASK  8'hE6
`define EIFP_PA_REQ0      3'h7
`define EIFP_PA_REQ1      3'h6
`define EIFP_PA_REQ23     3'h5
`define EIFP_PA_REQ45     3'h4
`define EIFP_PA_WDOG_REF  3'h3
`define EIFP_PA_TMR0      3'h2
`define EIFP_PA_TMR1      3'h1
`define EIFP_PA_TMR2      3'h0
`define EIFP_PB_TMR3      3'h7
`define EIFP_PB_TMR4      3'h6
`define EIFP_PB_DMA       3'h5
`define EIFP_PB_SER1      3'h2
`define EIFP_PB_ADC       3'h1
`endif

// ==== rtl/eifp_pkg.sv ====
// Purpose: Shared types of the request controller
// Assumes: Used with package-qualified names only
// Notes:   Register select codes for the APB decode
`default_nettype none
package eifp_pkg;
   // Which register an APB address hits
   typedef enum logic [3:0] {
      EIFP_SEL_NONE = 4'h0, EIFP_SEL_SENSE = 4'h1, EIFP_SEL_ENABLE = 4'h2,
      EIFP_SEL_FLAGS = 4'h3, EIFP_SEL_PRIO_A = 4'h4, EIFP_SEL_PRIO_B = 4'h5,
      EIFP_SEL_EVT_STAT = 4'h6, EIFP_SEL_EVT_CLR = 4'h7, EIFP_SEL_EVT_EN = 4'h8
   } eifp_sel_t;
endpackage : eifp_pkg
`default_nettype wire

// ==== rtl/eifp_det_if.sv ====
// Purpose: Carries pin conditions and flag controls between block parts
// Assumes: All signals on pclk
// Notes:   One bit per request input
`default_nettype none
interface eifp_det_if #(parameter int N = 6);
   logic [N-1:0] in_low;   // Synchronised input is low
   logic [N-1:0] fall;     // One-cycle falling edge
   logic [N-1:0] sense;    // 1 edge mode, 0 level mode
   logic [N-1:0] ack;      // Exception handling pulse
   logic [N-1:0] sw_clr;   // Armed software clear
   logic [N-1:0] flag;     // Status flags
   modport det  (output in_low, output fall);
   modport bank (input in_low, input fall, input sense, input ack, input sw_clr,
                 output flag);
endinterface : eifp_det_if
`default_nettype wire

// ==== rtl/eifp_detect.sv ====
// Purpose: Synchronises request pins and finds low levels and falling edges
// Assumes: Pins are asynchronous to pclk
// Notes:   Two flops before any logic looks at a pin
`default_nettype none
module eifp_detect #(
   parameter int N = 6
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [N-1:0] pin_in,
   eifp_det_if.det           dif
);
   // Pins idle high, so synchronisers reset high to avoid a false edge
   genvar g;
   for (g = 0; g < N; g++)
   begin : g_bit
      logic sync1_reg;  // Metastability catcher, read only by sync2
      logic sync2_reg;  // Stable level
      logic prev_reg;   // Level one cycle earlier
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            prev_reg  <= 1'b1;
         end
         else
         begin
            sync1_reg <= pin_in[g];
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
         end
      end
      assign dif.in_low[g] = ~sync2_reg;
      assign dif.fall[g]   = prev_reg & ~sync2_reg;
      // Edge pulse only where level just went low
      a_fall_pulse : assert property (@(posedge pclk) disable iff (!presetn)
         dif.fall[g] |=> !dif.fall[g]) else $error("edge pulse too long");
   end
endmodule : eifp_detect
`default_nettype wire

// ==== rtl/eifp_flag_bank.sv ====
// Purpose: Status flags of the request inputs
// Assumes: Acks and clears come from logic on pclk
// Notes:   A set in the same cycle as a clear wins
`default_nettype none
module eifp_flag_bank #(
   parameter int N = 6
) (
   input  wire logic pclk,
   input  wire logic presetn,
   eifp_det_if.bank  dif
);
   genvar g;
   for (g = 0; g < N; g++)
   begin : g_flag
      logic flag_reg;  // Sticky status flag
      logic set_c;     // Setting condition
      logic clr_c;     // Clearing condition
      // Level mode sets while low, edge mode on a fall
      assign set_c = dif.sense[g] ? dif.fall[g] : dif.in_low[g];
      // Ack clears: edge mode always, level mode only with pin high
      assign clr_c = dif.sw_clr[g] | (dif.ack[g] & (dif.sense[g] | ~dif.in_low[g]));
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            flag_reg <= 1'b0;
         else if (set_c)
            flag_reg <= 1'b1;
         else if (clr_c)
            flag_reg <= 1'b0;
      end
      assign dif.flag[g] = flag_reg;
      a_level_set : assert property (@(posedge pclk) disable iff (!presetn)
         !dif.sense[g] && dif.in_low[g] |=> dif.flag[g]) else $error("level set lost");
      a_edge_set : assert property (@(posedge pclk) disable iff (!presetn)
         dif.sense[g] && dif.fall[g] |=> dif.flag[g]) else $error("edge set lost");
      a_edge_ack : assert property (@(posedge pclk) disable iff (!presetn)
         dif.sense[g] && dif.ack[g] && !dif.fall[g] |=> !dif.flag[g])
         else $error("edge ack did not clear");
      a_level_ack : assert property (@(posedge pclk) disable iff (!presetn)
         !dif.sense[g] && dif.ack[g] && dif.flag[g] && dif.in_low[g] |=> dif.flag[g])
         else $error("level ack cleared while low");
   end
endmodule : eifp_flag_bank
`default_nettype wire

// ==== test/eifp_core_model.sv ====
// Purpose: Core side model answering requests with handling pulses
// Assumes: Same clock as the block, handling pulse one cycle wide
// Notes:   Answers promptly or after a long pause, one source at a time
`default_nettype none
module eifp_core_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [5:0] core_req,
   input  wire logic       ack_on,
   input  wire logic       slow,
   output logic      [5:0] exc_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   int wait_cnt; // Cycles the core spends before handling
   // Two cycles minimum so a stale request after a clear is not handled twice
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         exc_ack  <= 6'h00;
         wait_cnt <= 0;
      end
      else if (exc_ack != 6'h00 || !ack_on || core_req == 6'h00)
      begin
         exc_ack  <= 6'h00;
         wait_cnt <= 0;
      end
      else if (wait_cnt < (slow ? 6 : 2))
         wait_cnt <= wait_cnt + 1;
      else
      begin
         // Lowest pending input is handled first
         exc_ack  <= core_req & (~core_req + 6'h01);
         wait_cnt <= 0;
      end
   end
endmodule : eifp_core_model
`default_nettype wire

// ==== test/tb.sv ====
// Purpose: Self-checking bench of the request controller
// Assumes: APB reads return in the access cycle, pins idle high
// Notes:   Transfers note expected answers in a queue for the monitor
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0, presetn = 1'b0;          // Clock, reset
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;                     // Byte address
   logic [31:0] pwdata = 32'h0, prdata;              // Bus data
   logic [3:0]  pstrb = 4'hF;                        // Low byte strobe used
   logic        pready, pslverr, irq, ack_on = 1'b0, slow = 1'b0;
   logic [5:0]  pins = 6'h3F, exc_ack, core_req, req_prio;
   logic [4:0]  timer_prio;                          // Timer channels 0..4
   logic        watchdog_ref_prio, dma_prio, serial1_prio, adc_prio;
   logic [32:0] exp_q[$];                            // Notes {error, data}
   logic [32:0] exp_n;                               // Oldest note
   logic [31:0] v;                                   // Random priorities
   int          error_cnt = 0, compares = 0, cyc = 0, i, j;
   localparam logic [11:0] A_SEN = 12'h3D0, A_EN = 12'h3D4, A_FLG = 12'h3D8,
      A_PA = 12'h3E0, A_PB = 12'h3E4, A_ES = 12'h3E8, A_EC = 12'h3EC, A_EE = 12'h3F0;
   localparam logic [11:0] RST_A[7] = '{A_SEN, A_EN, A_FLG, A_PA, A_PB, A_ES, A_EE};
   // Clock of 10 ns period
   always #5 pclk = ~pclk;
   eifp_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_req_input(pins), .exc_ack(exc_ack),
      .core_req(core_req), .req_prio(req_prio), .watchdog_ref_prio(watchdog_ref_prio),
      .timer_prio(timer_prio), .dma_prio(dma_prio), .serial1_prio(serial1_prio),
      .adc_prio(adc_prio), .irq(irq));
   eifp_core_model i_core (.pclk(pclk), .presetn(presetn), .core_req(core_req),
      .ack_on(ack_on), .slow(slow), .exc_ack(exc_ack));
   // Single comparison point
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   // One APB transfer, held until pready is seen
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
      exp_q.push_back(e);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0; penable <= 1'b0;
   endtask : xfer
   // Let outputs settle n cycles, then look mid-cycle
   task automatic wt(input int n);
      repeat (n) @(negedge pclk);
   endtask : wt
   // Verdict and end of run
   task automatic results;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results
   // Monitor: every completed transfer takes the oldest note
   always @(posedge pclk)
      if (psel && penable && pready === 1'b1)
      begin
         exp_n = exp_q.pop_front();
         chk({pslverr, pwrite ? 32'h0 : prdata}, exp_n);
      end
   // Hang guard, far above the few hundred cycles needed
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         results();
      end
   end
   // Main sequence
   initial
   begin
      void'($urandom(41691));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      foreach (RST_A[k]) xfer(0, RST_A[k], 0, 33'h0);
      xfer(0, 12'h3F4, 0, {1'b1, 32'h0});
      xfer(1, 12'h3D6, 32'hFF, {1'b1, 32'h0});
      xfer(1, A_EN, 32'hFF, 33'h0);
      xfer(0, A_EN, 0, 33'h3F);
      // Low byte strobe off: the write must be ignored
      pstrb <= 4'hE;
      xfer(1, A_EN, 32'h0, 33'h0);
      pstrb <= 4'hF;
      xfer(0, A_EN, 0, 33'h3F);
      v = $urandom;
      xfer(1, A_PA, v, 33'h0);
      xfer(1, A_PB, v >> 8, 33'h0);
      xfer(0, A_PA, 0, 33'(v[7:0]));
      xfer(0, A_PB, 0, 33'(v[15:8] & 8'hE6));
      wt(2);
      chk(33'(req_prio), 33'({v[4], v[4], v[5], v[5], v[6], v[7]}));
      chk(33'({watchdog_ref_prio, timer_prio}),
          33'({v[3], v[14], v[15], v[0], v[1], v[2]}));
      chk(33'({dma_prio, serial1_prio, adc_prio}), 33'({v[13], v[10], v[9]}));
      // Edge mode on one random input, events enabled
      i = $urandom_range(5, 0);
      j = (i + 1) % 6;
      xfer(1, A_SEN, 32'h3F, 33'h0);
      xfer(1, A_EE, 32'h3F, 33'h0);
      pins[i] <= 1'b0;
      wt(7);
      chk(33'(core_req), 33'(1 << i));
      chk(33'(irq), 33'h1);
      xfer(0, A_ES, 0, 33'(1 << i));
      xfer(1, A_EC, 32'(1 << i), 33'h0);
      wt(3);
      chk(33'(irq), 33'h0);
      xfer(0, A_FLG, 0, 33'(1 << i));
      xfer(1, A_FLG, 32'hFF, 33'h0);
      xfer(1, A_FLG, 32'h0, 33'h0);
      xfer(0, A_FLG, 0, 33'(1 << i));
      xfer(1, A_FLG, 32'h0, 33'h0);
      xfer(0, A_FLG, 0, 33'h0);
      pins[i] <= 1'b1;
      // Level mode: flag holds while low, mask hides request
      xfer(1, A_SEN, 32'h0, 33'h0);
      pins[j] <= 1'b0;
      wt(7);
      xfer(0, A_FLG, 0, 33'(1 << j));
      xfer(1, A_FLG, 32'h0, 33'h0);
      xfer(0, A_FLG, 0, 33'(1 << j));
      xfer(1, A_EN, 32'(6'h3F & ~(6'h01 << j)), 33'h0);
      wt(3);
      chk(33'(core_req), 33'h0);
      xfer(1, A_EN, 32'h3F, 33'h0);
      ack_on <= 1'b1;
      wt(12);
      chk(33'(core_req), 33'(1 << j));
      @(posedge pclk);
      pins[j] <= 1'b1;
      wt(14);
      xfer(0, A_FLG, 0, 33'h0);
      // Every input in edge mode, slow core handling
      xfer(1, A_SEN, 32'h3F, 33'h0);
      slow <= 1'b1;
      for (int k = 0; k < 6; k++)
      begin
         pins[k] <= 1'b0;
         wt(24);
         xfer(0, A_FLG, 0, 33'h0);
         pins[k] <= 1'b1;
      end
      wt(1);
      chk(33'(irq), 33'h1);
      xfer(1, A_EE, 32'h0, 33'h0);
      wt(3);
      chk(33'(irq), 33'h0);
      results();
   end
endmodule : tb
`default_nettype wire
